// *** hdl/eacc_pkg.sv ***
// shared constants and types for the external area cycle controller
package eacc_pkg;
    localparam int         AREA_N     = 4;
    localparam int         PW_W       = 3;
    localparam int         BLEN_W     = 3;
    localparam logic [2:0] ADDR_SHORT = 3'h2;  // address phase cycles, extend off
    localparam logic [2:0] ADDR_LONG  = 3'h3;  // address phase cycles, extend on
    localparam logic [1:0] AREA0      = 2'h0;
    localparam logic [1:0] AREA1      = 2'h1;
    localparam logic [1:0] AREA2      = 2'h2;
    localparam logic [1:0] AREA3      = 2'h3;
    localparam logic [3:0] CS_IDLE_N  = 4'hf;

    typedef enum logic [9:0] {
        ST_IDLE    = 10'h001,
        ST_ADDR    = 10'h002,
        ST_HOLD    = 10'h004,
        ST_FIRST   = 10'h008,
        ST_SECOND  = 10'h010,
        ST_PWAIT   = 10'h020,
        ST_PINWAIT = 10'h040,
        ST_THIRD   = 10'h080,
        ST_TAIL    = 10'h100,
        ST_BURST   = 10'h200
    } eacc_state_e;

    typedef enum logic [1:0] {
        IF_BASIC = 2'h0,
        IF_BSRAM = 2'h1,
        IF_BURST = 2'h2,
        IF_MUX   = 2'h3
    } eacc_iface_e;

    // per-area access timing
    typedef struct packed {
        logic            hold_en;
        logic            tail_en;
        logic            three_state;
        logic [PW_W-1:0] prog_wait;
    } eacc_timing_s;

    // one access request from the internal bus
    typedef struct packed {
        logic [1:0] area;
        logic       in_rom;
        logic [5:0] burst_count;
    } eacc_req_s;
endpackage

// *** hdl/eacc_area_cycle_control.sv ***
// external area access-cycle sequencer with interface select and chip selects
// Summary of operation
// - burst ROM: first access like basic, later accesses last 1 to 8 cycles
// - burst total: basic part, waits, no tail cycle, burst length times 0-63
// - multiplexed data phase like basic; address phase 2 or 3 by extend bit
// - multiplexed total: address plus data, program waits, tail cycles, pin waits
// - basic order: hold, first, second, program waits, pin waits, third, tail
// - multiplexed address states come before hold, data and wait states
// - read strobe, chip-select extension and DMA acknowledge timing adjustable
// - in extended mode area 0 external whole without ROM, outside ROM only with ROM enabled
// - active-low chip select of an area asserts while its external space is accessed
// - area 0 select: 00 basic, 01 byte SRAM, 10 burst ROM, 11 prohibited
// - area 1 uses the same select encoding as area 0
// - area 2 offers basic or byte SRAM only
// - area 3 offers basic, byte SRAM or multiplexed by its two bits
// - areas 2 and 3 are wholly external in extended mode
// - with ROM enabled areas 0 and 1 are external only outside the ROM
// - 2-state areas take no waits; 3-state take 0-7 program waits, then pin waits for as long as the pin holds
// - byte SRAM areas always use a 16-bit data bus
`timescale 1ns/1ps
module eacc_area_cycle_control
    import eacc_pkg::*;
#(
    parameter int BURST_N_W = 6
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic         req_valid,
    input  wire eacc_req_s    req,
    output logic              req_ready,
    output logic              done,
    output logic              req_internal,
    input  wire logic         extended_mode,
    input  wire logic         rom_enable,
    input  wire eacc_timing_s area_timing [AREA_N],
    input  wire logic [3:0]   area_bus16,
    input  wire logic         burst_rom_select_area0,
    input  wire logic         burst_rom_select_area1,
    input  wire logic         byte_sram_select_area0,
    input  wire logic         byte_sram_select_area1,
    input  wire logic         byte_sram_select_area2,
    input  wire logic         byte_sram_select_area3,
    input  wire logic         multiplex_enable_area3,
    input  wire logic         address_cycle_extend,
    input  wire logic [2:0]   burst_cycle_count,
    input  wire logic         wait_enable,
    input  wire logic         wait_n,
    input  wire logic         rd_late_assert,
    input  wire logic         dack_on_strobe,
    output logic              area0_select_n,
    output logic              area1_select_n,
    output logic              area2_select_n,
    output logic              area3_select_n,
    output logic              rd_n,
    output logic              dma_transfer_ack_n,
    output logic              address_phase,
    output logic              bus16,
    output eacc_iface_e       iface,
    output logic              config_error,
    output eacc_state_e       cycle_state
);
    if (BURST_N_W != 6) begin : g_bad_width
        $error("burst count width must be 6");
    end

    eacc_state_e         state;
    eacc_state_e         next_state;
    eacc_iface_e         cur_iface;
    eacc_timing_s        cur_tm;
    eacc_timing_s        tm;
    logic [1:0]          cur_area;
    logic                cur_addr_ext;
    logic [BLEN_W-1:0]   cur_blen;
    logic [5:0]          cnt;
    logic [BURST_N_W-1:0] bleft;
    logic                wait_meta;
    logic                wait_sync;
    logic                wait_active;
    logic                ext;
    logic                take;
    logic [1:0]          next_area;
    eacc_iface_e         next_iface;
    logic [3:0]          cs_n;

    // interface style of an area from its select bits
    function automatic eacc_iface_e iface_of(input logic [1:0] a);
        case (a)
            AREA0:   iface_of = burst_rom_select_area0 && !byte_sram_select_area0 ? IF_BURST
                              : byte_sram_select_area0 ? IF_BSRAM : IF_BASIC;
            AREA1:   iface_of = burst_rom_select_area1 && !byte_sram_select_area1 ? IF_BURST
                              : byte_sram_select_area1 ? IF_BSRAM : IF_BASIC;
            AREA2:   iface_of = byte_sram_select_area2 ? IF_BSRAM : IF_BASIC;
            default: iface_of = multiplex_enable_area3 && !byte_sram_select_area3 ? IF_MUX
                              : byte_sram_select_area3 ? IF_BSRAM : IF_BASIC;
        endcase
    endfunction

    // states in which the chip select or read strobe is active
    function automatic logic cs_on(input eacc_state_e s, input logic tail_cs);
        cs_on = !(s inside {ST_IDLE, ST_HOLD, ST_TAIL}) || (s == ST_TAIL && tail_cs);
    endfunction

    function automatic logic rd_on(input eacc_state_e s, input logic late);
        rd_on = (s inside {ST_SECOND, ST_PWAIT, ST_PINWAIT, ST_THIRD, ST_BURST})
             || (s == ST_FIRST && !late);
    endfunction

    // two-flop synchroniser for the external wait pin
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wait_meta <= 1'b1;
            wait_sync <= 1'b1;
        end else begin
            wait_meta <= wait_n;
            wait_sync <= wait_meta;
        end
    end
    assign wait_active = wait_enable && !wait_sync;

    // external space decode per area
    always_comb begin
        case (req.area)
            AREA0, AREA1: ext = extended_mode && !(rom_enable && req.in_rom);
            default:      ext = extended_mode;
        endcase
    end
    assign req_ready = (state == ST_IDLE);
    assign take      = req_ready && req_valid && ext;
    assign tm        = req_ready ? area_timing[req.area] : cur_tm;
    assign next_area = req_ready ? req.area : cur_area;
    assign next_iface = req_ready ? iface_of(req.area) : cur_iface;

    // access state sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    if (iface_of(req.area) == IF_MUX) next_state = ST_ADDR;
                    else next_state = tm.hold_en ? ST_HOLD : ST_FIRST;
                end
            end
            ST_ADDR: begin
                if (cnt[2:0] == (cur_addr_ext ? ADDR_LONG : ADDR_SHORT) - 3'h1) begin
                    next_state = tm.hold_en ? ST_HOLD : ST_FIRST;
                end
            end
            ST_HOLD:  next_state = ST_FIRST;
            ST_FIRST: next_state = ST_SECOND;
            ST_SECOND: begin
                if (!tm.three_state) begin
                    next_state = ST_TAIL;
                end else if (tm.prog_wait != '0) begin
                    next_state = ST_PWAIT;
                end else begin
                    next_state = wait_active ? ST_PINWAIT : ST_THIRD;
                end
            end
            ST_PWAIT: begin
                if (cnt[PW_W-1:0] == tm.prog_wait - 3'h1) begin
                    next_state = wait_active ? ST_PINWAIT : ST_THIRD;
                end
            end
            ST_PINWAIT: next_state = wait_active ? ST_PINWAIT : ST_THIRD;
            ST_THIRD:   next_state = ST_TAIL;
            ST_BURST: begin
                if (cnt[BLEN_W-1:0] == cur_blen && bleft == 6'h01) next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
        // after the data part: bursts follow, else optional tail
        if (next_state == ST_TAIL && state != ST_TAIL) begin
            if (cur_iface == IF_BURST) begin
                next_state = (bleft != '0) ? ST_BURST : ST_IDLE;
            end else if (!tm.tail_en) begin
                next_state = ST_IDLE;
            end
        end
        if (state == ST_TAIL) next_state = ST_IDLE;
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (reset) state <= ST_IDLE;
        else       state <= next_state;
    end

    // per-state cycle counter, one count per bus clock
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cnt <= '0;
        end else if (next_state != state) begin
            cnt <= '0;
        end else if (state == ST_BURST && cnt[BLEN_W-1:0] == cur_blen) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 6'h01;
        end
    end

    // access context captured when the request is taken
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cur_area     <= AREA0;
            cur_iface    <= IF_BASIC;
            cur_tm       <= '0;
            cur_addr_ext <= 1'b0;
            cur_blen     <= '0;
            bleft        <= '0;
        end else if (take) begin
            cur_area     <= req.area;
            cur_iface    <= iface_of(req.area);
            cur_tm       <= area_timing[req.area];
            cur_addr_ext <= address_cycle_extend;
            cur_blen     <= burst_cycle_count;
            bleft        <= req.burst_count;
        end else if (state == ST_BURST && cnt[BLEN_W-1:0] == cur_blen) begin
            bleft <= bleft - 6'h01;
        end
    end

    // registered strobes and status
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cs_n               <= CS_IDLE_N;
            rd_n               <= 1'b1;
            dma_transfer_ack_n <= 1'b1;
            address_phase      <= 1'b0;
            bus16              <= 1'b0;
            iface              <= IF_BASIC;
            config_error       <= 1'b0;
            done               <= 1'b0;
            req_internal       <= 1'b0;
            cycle_state        <= ST_IDLE;
        end else begin
            cs_n <= CS_IDLE_N;
            if (cs_on(next_state, tm.tail_en)) cs_n[next_area] <= 1'b0;
            rd_n <= !rd_on(next_state, rd_late_assert);
            dma_transfer_ack_n <= dack_on_strobe ? !rd_on(next_state, rd_late_assert)
                                                 : !cs_on(next_state, tm.tail_en);
            address_phase <= (next_state == ST_ADDR);
            bus16         <= (next_iface == IF_BSRAM) || area_bus16[next_area];
            iface         <= next_iface;
            config_error  <= (burst_rom_select_area0 && byte_sram_select_area0)
                          || (burst_rom_select_area1 && byte_sram_select_area1)
                          || (multiplex_enable_area3 && byte_sram_select_area3);
            done          <= (state != ST_IDLE) && (next_state == ST_IDLE);
            req_internal  <= req_ready && req_valid && !ext;
            cycle_state   <= next_state;
        end
    end
    assign area0_select_n = cs_n[0];
    assign area1_select_n = cs_n[1];
    assign area2_select_n = cs_n[2];
    assign area3_select_n = cs_n[3];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence seq_pwait3;
        (state == ST_PWAIT) [*3] ##1 (state != ST_PWAIT);
    endsequence
    sequence seq_addr_long;
        (state == ST_ADDR) [*3] ##1 (state == ST_HOLD || state == ST_FIRST);
    endsequence

    chk_two_state_nowait: assert property (
        state == ST_SECOND && !cur_tm.three_state |=>
            !(state inside {ST_PWAIT, ST_PINWAIT, ST_THIRD}))
        else $error("wait inserted in 2-state area");
    chk_prog_wait_len: assert property (
        state == ST_SECOND && cur_tm.three_state && cur_tm.prog_wait == 3'h3 |=> seq_pwait3)
        else $error("program wait length wrong");
    chk_addr_phase_len: assert property (
        $rose(state == ST_ADDR) && cur_addr_ext |-> seq_addr_long)
        else $error("long address phase wrong");
    chk_burst_len: assert property (
        state == ST_BURST && cnt == 6'h00 && cur_blen == 3'h7 && bleft > 6'h01 |->
            (state == ST_BURST) [*8] ##1 (state == ST_BURST && cnt == 6'h00))
        else $error("burst access length wrong");
    chk_pin_wait_hold: assert property (
        state == ST_PINWAIT && wait_active |=> state == ST_PINWAIT)
        else $error("pin wait released early");
    chk_area2_iface: assert property (
        take && req.area == AREA2 |=> cur_iface == IF_BASIC || cur_iface == IF_BSRAM)
        else $error("illegal area 2 interface");
    chk_cs_first: assert property (
        state == ST_FIRST |-> cs_n[cur_area] == 1'b0 && $countones(cs_n) == 3)
        else $error("chip select not asserted");
    chk_rom_internal: assert property (
        req_ready && req_valid && extended_mode && rom_enable && req.in_rom &&
            req.area == AREA0 |=> req_internal && state == ST_IDLE && cs_n == CS_IDLE_N)
        else $error("on-chip ROM access went external");
    chk_bsram_bus16: assert property (
        state != ST_IDLE && cur_iface == IF_BSRAM |-> bus16)
        else $error("byte SRAM not 16-bit");
endmodule

// *** testbench/eacc_ext_mem_model.sv ***
// external memory model that can hold the wait pin asserted
`timescale 1ns/1ps
module eacc_ext_mem_model (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [3:0] cs_n,
    input  wire logic       stall,
    input  wire logic [3:0] wait_len,
    output logic            wait_n
);
    logic [3:0] held;

    // selected cycles seen in this access, cleared once deselected
    always_ff @(posedge sys_clk) begin
        if (reset || &cs_n) begin
            held <= 4'h0;
        end else if (held != 4'hf) begin
            held <= held + 4'h1;
        end
    end

    // slow device holds wait low only while selected, pull-up keeps it high otherwise
    assign wait_n = !(stall && !(&cs_n) && held < wait_len);
endmodule

// *** testbench/eacc_area_cycle_control_bench.sv ***
// randomised access-length bench for the area cycle controller
`timescale 1ns/1ps
module eacc_area_cycle_control_bench
    import eacc_pkg::*;
;
    logic         sys_clk = 1'b0;
    logic         reset   = 1'b1;
    logic         req_valid = 1'b0;
    eacc_req_s    req = '0;
    logic         req_ready, done, req_internal, rd_n, ack_n, address_phase, bus16;
    logic         extended_mode = 1'b1, rom_enable = 1'b0, mx3 = 1'b0, adx = 1'b0;
    logic         wait_enable = 1'b0, rd_late = 1'b0, dack_s = 1'b0, stall = 1'b0;
    logic [1:0]   brs = 2'h0;
    logic [3:0]   bcs = 4'h0, bus_w = 4'h0, cs_n, wait_len = 4'hc;
    logic [2:0]   blen = 3'h0;
    logic         wait_n, config_error;
    eacc_timing_s tim [AREA_N] = '{default: '0};
    eacc_iface_e  iface;
    eacc_state_e  cycle_state;
    int           fails = 0, cmp_count = 0, seed = 6;

    // 250 MHz bus clock
    always #2 sys_clk = ~sys_clk;

    eacc_area_cycle_control dut (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .done(done), .req_internal(req_internal),
        .extended_mode(extended_mode), .rom_enable(rom_enable), .area_timing(tim),
        .area_bus16(bus_w), .burst_rom_select_area0(brs[0]), .burst_rom_select_area1(brs[1]),
        .byte_sram_select_area0(bcs[0]), .byte_sram_select_area1(bcs[1]),
        .byte_sram_select_area2(bcs[2]), .byte_sram_select_area3(bcs[3]),
        .multiplex_enable_area3(mx3), .address_cycle_extend(adx), .burst_cycle_count(blen),
        .wait_enable(wait_enable), .wait_n(wait_n), .rd_late_assert(rd_late),
        .dack_on_strobe(dack_s), .area0_select_n(cs_n[0]), .area1_select_n(cs_n[1]),
        .area2_select_n(cs_n[2]), .area3_select_n(cs_n[3]), .rd_n(rd_n),
        .dma_transfer_ack_n(ack_n), .address_phase(address_phase), .bus16(bus16),
        .iface(iface), .config_error(config_error), .cycle_state(cycle_state));

    eacc_ext_mem_model mem (.sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .stall(stall),
        .wait_len(wait_len), .wait_n(wait_n));

    // compare and count
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // interface expected from the select bits of an area
    function automatic eacc_iface_e exp_iface(input logic [1:0] a);
        if (a < 2 && brs[a[0]] && !bcs[a]) return IF_BURST;
        if (a == 3 && mx3 && !bcs[a]) return IF_MUX;
        return bcs[a] ? IF_BSRAM : IF_BASIC;
    endfunction

    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // one random access, timed against the reference sum of states
    task automatic run_one(input int n);
        int a, k, busy, adr, pw, bst, bad, ex, tot, addr_n, bst_n;
        eacc_iface_e ei;
        logic three, rd_exp, early;
        busy = 0; adr = 0; pw = 0; bst = 0; bad = 0;
        extended_mode = ($random(seed) % 8) != 0;
        {rom_enable, mx3, adx, wait_enable, rd_late, dack_s, stall} = 7'($random(seed));
        {brs, bcs, bus_w} = 10'($random(seed));
        blen = 3'($random(seed));
        for (k = 0; k < AREA_N; k++) tim[k] = 6'($random(seed));
        req = 9'($random(seed));
        a = req.area;
        ei = exp_iface(req.area);
        three = tim[a].three_state;
        ex = extended_mode && (a >= 2 || !(rom_enable && req.in_rom));
        req_valid = 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        req_valid = 1'b0;
        for (k = 0; k < 700 && done !== 1'b1 && req_internal !== 1'b1; k++) begin
            if (cycle_state !== ST_IDLE) begin
                busy++;
                if (busy == 1) begin
                    check("interface", ei, iface);
                    check("bus16", ei == IF_BSRAM || bus_w[a], bus16);
                end
            end
            if (address_phase === 1'b1) adr++;
            if (cycle_state === ST_PINWAIT) pw++;
            if (cycle_state === ST_BURST) bst++;
            if (cycle_state === ST_IDLE || cycle_state === ST_HOLD) begin
                if (cs_n !== CS_IDLE_N) bad++;
            end else if (cycle_state !== ST_ADDR) begin
                if (cs_n !== ~(4'h1 << a)) bad++;
                if (!dack_s && ack_n !== 1'b0) bad++;
            end
            rd_exp = (cycle_state inside {ST_SECOND, ST_PWAIT, ST_PINWAIT, ST_THIRD, ST_BURST})
                  || (cycle_state === ST_FIRST && !rd_late);
            if (rd_n !== !rd_exp) bad++;
            if (dack_s && ack_n !== rd_n) bad++;
            @(negedge sys_clk);
        end
        check("no hang", 1, k < 700);
        check("internal", !ex, req_internal);
        check("config error", (brs[0] && bcs[0]) || (brs[1] && bcs[1]) || (mx3 && bcs[3]),
              config_error);
        if (ex) begin
            addr_n = (ei == IF_MUX) ? (adx ? 3 : 2) : 0;
            bst_n = (ei == IF_BURST) ? req.burst_count * (blen + 1) : 0;
            tot = addr_n + tim[a].hold_en + 2 + bst_n + (tim[a].tail_en && ei != IF_BURST);
            if (three) tot = tot + tim[a].prog_wait + pw + 1;
            check("length", tot, busy);
            check("address cycles", addr_n, adr);
            check("burst cycles", bst_n, bst);
            // pin reaches the decision two cycles late through the synchroniser
            early = tim[a].prog_wait != 0 || (ei == IF_MUX && !tim[a].hold_en);
            if (three && wait_enable && stall && early) check("pin wait seen", 1, pw > 0);
            else check("no pin wait", 0, pw);
            check("select cycles", 0, bad);
        end
        $display("access %0d area %0d states %0d done", n, a, busy);
        if (!ex) @(negedge sys_clk);
    endtask

    // give up if the accesses hang
    initial begin
        #(4 * 90000);
        fails++;
        $display("[FAIL] watchdog expected finish seen hang");
        complete_run();
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        for (int n = 0; n < 80; n++) run_one(n);
        complete_run();
    end
endmodule
